//--- design/sas_clk_div.v
// Bit-period tick generator: divides the system clock or follows the RC tick
`timescale 1ns/10ps
`default_nettype none
`include "sas_defs.vh"

module sas_clk_div (
  input  wire       ref_clk_in,
  input  wire       resetn_in,
  input  wire       run_in,
  input  wire [2:0] clk_sel_in,
  input  wire       rc_tick_in,
  output wire       half_tick_out,
  output wire       tick_out
);

  // -------------------------------------------------------------------
  // Divide ratio decode
  // -------------------------------------------------------------------
  reg  [5:0] sel_q;
  reg  [5:0] cnt_q;
  reg        half_q;
  wire       is_rc;

  // Half-ratio minus one for a system-clock divide setting
  function [5:0] half_ratio_m1;
    input [2:0] sel;
    begin
      case (sel)
        `SAS_CLK_DIV2:  half_ratio_m1 = 6'h00;
        `SAS_CLK_DIV4:  half_ratio_m1 = 6'h01;
        `SAS_CLK_DIV8:  half_ratio_m1 = 6'h03;
        `SAS_CLK_DIV16: half_ratio_m1 = 6'h07;
        `SAS_CLK_DIV32: half_ratio_m1 = 6'h0f;
        `SAS_CLK_DIV64: half_ratio_m1 = 6'h1f;
        default:        half_ratio_m1 = 6'h00;
      endcase
    end
  endfunction

  assign is_rc = (clk_sel_in[1:0] == `SAS_CLK_RC_LOW);

  // -------------------------------------------------------------------
  // Counter; ratio latched only while idle so a running bit stays even
  // -------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      sel_q  <= 6'h00;
      cnt_q  <= 6'h00;
      half_q <= 1'b1;
    end else if (!run_in) begin
      // Phase starts high so the first half of a run already ticks
      sel_q  <= half_ratio_m1(clk_sel_in);
      cnt_q  <= 6'h00;
      half_q <= 1'b1;
    end else if (is_rc) begin
      if (rc_tick_in) begin
        half_q <= ~half_q;
      end
    end else if (cnt_q == sel_q) begin
      cnt_q  <= 6'h00;
      half_q <= ~half_q;
    end else begin
      cnt_q <= cnt_q + 6'h01;
    end
  end

  // Half-period strobe; full tick on every second half
  assign half_tick_out = run_in & (is_rc ? rc_tick_in : (cnt_q == sel_q));
  assign tick_out      = half_tick_out & half_q;

endmodule // sas_clk_div
`default_nettype wire

//--- design/sas_sequencer.v
// Successive-approximation converter sequencer top level
//
// Function
// - Channel field routes one of five sources to the sampler; codes 3..5 route none.
// - Only supply is the upper reference; fixed reference is a channel only.
// - Three-bit clock field picks system divide 2..64 or the RC clock.
// - One bit per period, MSB first, whole conversion 9.5 periods.
// - Divided clocks track system clock frequency proportionally.
// - No conversion runs unless the enable bit is set.
// - Writing go while enabled starts converting the selected channel.
// - Completion clears go, sets the flag, loads the result together.
// - Flag sets on every completion; only a software write or reset clears it.
// - Flag and enable both set request an interrupt and wake from sleep.
// - Clearing go mid-conversion loads partial result, low bits copy last.
// - Reset returns all registers to reset values and ends any conversion.
// - Conversions continue in sleep only on the RC clock.
// - RC clock start is delayed one instruction cycle after go.
// - Sleep conversion without interrupt powers down after, enable kept.
// - Sleep on a system-derived clock aborts and powers down, enable kept.
// - Each eight-bit result is stored in a readable result register.
`timescale 1ns/10ps
`default_nettype none
`include "sas_defs.vh"

module sas_sequencer #(
  parameter        INSTR_CYCLES = 4
) (
  input  wire       ref_clk_in,
  input  wire       resetn_in,
  // Control register image, written by software
  input  wire       ctrl_wr_in,
  input  wire [2:0] conv_clock_select_in,
  input  wire [2:0] channel_select_in,
  input  wire       go_in,
  input  wire       converter_enable_in,
  // Flag register access
  input  wire       flag_clr_in,
  input  wire       conv_complete_irq_enable_in,
  input  wire       sleep_in,
  input  wire       rc_tick_in,
  // Comparator answer for the trial bit
  input  wire       cmp_high_in,
  output reg  [2:0] conv_clock_select_out,
  output reg  [2:0] channel_select_out,
  output wire       go_out,
  output reg        converter_enable_out,
  output reg        conv_complete_flag_out,
  output reg  [7:0] conv_result_reg_out,
  output reg  [4:0] mux_sel_out,
  output wire       vref_supply_out,
  output wire       sample_hold_out,
  output reg  [7:0] dac_trial_out,
  output wire       analog_power_out,
  output wire       irq_out,
  output wire       wake_out
);

  // -------------------------------------------------------------------
  // States
  // -------------------------------------------------------------------
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_DELAY = 2'h1;
  localparam [1:0] ST_HALF  = 2'h2;
  localparam [1:0] ST_CONV  = 2'h3;

  reg  [1:0] state_q;
  reg  [3:0] bit_q;
  reg  [7:0] sar_q;
  reg  [7:0] dly_q;
  reg        pwr_down_q;
  wire       half_tick;
  wire       tick;
  wire       run;
  wire       is_rc;
  wire       sw_abort;
  wire       sleep_abort;
  wire       last_bit;
  wire [7:0] trial_bit;
  wire [7:0] resolved;

  // Partial result fill: bits below the last resolved copy that bit
  function [7:0] fill_low;
    input [7:0] val;
    input [3:0] nxt;
    integer     i;
    reg         lastv;
    begin
      fill_low = val;
      lastv    = 1'b0;
      if (nxt != `SAS_BIT_MSB) begin
        lastv = val[nxt[2:0] + 3'h1];
      end
      for (i = 0; i < 8; i = i + 1) begin
        if (i <= nxt) begin
          fill_low[i] = lastv;
        end
      end
    end
  endfunction

  assign is_rc       = (conv_clock_select_out[1:0] == `SAS_CLK_RC_LOW);
  assign run         = (state_q == ST_HALF) || (state_q == ST_CONV);
  assign sw_abort    = ctrl_wr_in && !go_in && (state_q != ST_IDLE);
  assign sleep_abort = sleep_in && !is_rc && (state_q != ST_IDLE);
  assign last_bit    = (bit_q == 4'h0);
  assign trial_bit   = 8'h01 << bit_q[2:0];
  assign resolved    = cmp_high_in ? (sar_q | trial_bit) : sar_q;

  // -------------------------------------------------------------------
  // Bit-period generator
  // -------------------------------------------------------------------
  sas_clk_div u_div (
    .ref_clk_in    (ref_clk_in),
    .resetn_in     (resetn_in),
    .run_in        (run),
    .clk_sel_in    (conv_clock_select_out),
    .rc_tick_in    (rc_tick_in),
    .half_tick_out (half_tick),
    .tick_out      (tick)
  );

  // -------------------------------------------------------------------
  // Control fields; select fields only change while idle
  // -------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      conv_clock_select_out <= `SAS_RST_CLKSEL;
      channel_select_out    <= `SAS_RST_CHSEL;
      converter_enable_out  <= 1'b0;
    end else if (ctrl_wr_in) begin
      converter_enable_out <= converter_enable_in;
      if (state_q == ST_IDLE) begin
        conv_clock_select_out <= conv_clock_select_in;
        channel_select_out    <= channel_select_in;
      end
    end
  end

  // -------------------------------------------------------------------
  // Conversion sequencer
  // -------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      state_q             <= ST_IDLE;
      bit_q               <= `SAS_BIT_MSB;
      sar_q               <= 8'h00;
      dly_q               <= 8'h00;
      conv_result_reg_out <= `SAS_RST_RESULT;
    end else begin
      case (state_q)
        ST_IDLE: begin
          bit_q <= `SAS_BIT_MSB;
          sar_q <= 8'h00;
          // Go only counts when already enabled before this write
          if (ctrl_wr_in && go_in && converter_enable_out && converter_enable_in) begin
            dly_q   <= is_rc ? INSTR_CYCLES[7:0] : 8'h01;
            state_q <= is_rc ? ST_DELAY : ST_HALF;
          end
        end
        ST_DELAY: begin
          if (sw_abort) begin
            state_q <= ST_IDLE;
          end else if (dly_q <= 8'h01) begin
            dly_q   <= 8'h01;
            state_q <= ST_HALF;
          end else begin
            dly_q <= dly_q - 8'h01;
          end
        end
        ST_HALF: begin
          // Half period plus one sample period before b7: 9.5 in all
          if (sw_abort || sleep_abort) begin
            conv_result_reg_out <= 8'h00;
            state_q             <= ST_IDLE;
          end else if (tick && dly_q != 8'h00) begin
            dly_q <= 8'h00;
          end else if (tick) begin
            state_q <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (sw_abort || sleep_abort) begin
            conv_result_reg_out <= fill_low(sar_q, bit_q);
            state_q             <= ST_IDLE;
          end else if (tick) begin
            sar_q <= resolved;
            if (last_bit) begin
              conv_result_reg_out <= resolved;
              state_q             <= ST_IDLE;
            end else begin
              bit_q <= bit_q - 4'h1;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
      // A write turning the enable off stops the run at once
      if (!converter_enable_out || (ctrl_wr_in && !converter_enable_in)) begin
        state_q <= ST_IDLE;
      end
    end
  end

  // -------------------------------------------------------------------
  // Completion flag: set wins over a same-cycle clear
  // -------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      conv_complete_flag_out <= 1'b0;
    end else if (state_q == ST_CONV && tick && last_bit && !sw_abort && !sleep_abort) begin
      conv_complete_flag_out <= 1'b1;
    end else if (flag_clr_in) begin
      conv_complete_flag_out <= 1'b0;
    end
  end

  // -------------------------------------------------------------------
  // Analog power-down in sleep, enable bit left untouched
  // -------------------------------------------------------------------
  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      pwr_down_q <= 1'b0;
    end else if (!sleep_in) begin
      pwr_down_q <= 1'b0;
    end else if (sleep_abort) begin
      pwr_down_q <= 1'b1;
    end else if (state_q == ST_IDLE && !conv_complete_irq_enable_in) begin
      pwr_down_q <= 1'b1;
    end else if (!is_rc && state_q == ST_IDLE) begin
      pwr_down_q <= 1'b1;
    end
  end

  // -------------------------------------------------------------------
  // Analog front end drive
  // -------------------------------------------------------------------
  always @* begin
    case (channel_select_out)
      `SAS_CH_PIN0: mux_sel_out = 5'h01;
      `SAS_CH_PIN1: mux_sel_out = 5'h02;
      `SAS_CH_PIN2: mux_sel_out = 5'h04;
      `SAS_CH_TEMP: mux_sel_out = 5'h08;
      `SAS_CH_FVR:  mux_sel_out = 5'h10;
      default:      mux_sel_out = 5'h00;                   // Reserved codes
    endcase
  end

  always @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      dac_trial_out <= 8'h00;
    end else begin
      dac_trial_out <= (state_q == ST_CONV) ? (sar_q | trial_bit) : 8'h00;
    end
  end

  assign vref_supply_out  = 1'b1;
  assign sample_hold_out  = !run;                          // Track while idle
  assign analog_power_out = converter_enable_out & !pwr_down_q;
  assign go_out           = (state_q != ST_IDLE);
  assign irq_out          = conv_complete_flag_out & conv_complete_irq_enable_in;
  assign wake_out         = irq_out & sleep_in;

endmodule // sas_sequencer
`default_nettype wire

//--- pkg/sas_defs.vh
// Constant definitions for the converter sequencer
`ifndef SAS_DEFS_VH
`define SAS_DEFS_VH

// Clock select encodings (3 bits; RC code matches the low 2 bits)
`define SAS_CLK_DIV2       3'h0
`define SAS_CLK_DIV4       3'h4
`define SAS_CLK_DIV8       3'h1
`define SAS_CLK_DIV16      3'h5
`define SAS_CLK_DIV32      3'h2
`define SAS_CLK_DIV64      3'h6
`define SAS_CLK_RC_LOW     2'h3

// Channel select encodings (3 bits)
`define SAS_CH_PIN0        3'h0
`define SAS_CH_PIN1        3'h1
`define SAS_CH_PIN2        3'h2
`define SAS_CH_TEMP        3'h6
`define SAS_CH_FVR         3'h7

// Reset values
`define SAS_RST_CLKSEL     3'h0
`define SAS_RST_CHSEL      3'h0
`define SAS_RST_RESULT     8'h00

// Result width and bit count
`define SAS_RES_W          8
`define SAS_NBITS          4'h8

// Bit-period phases: half period plus one sample period before b7 then eight bit periods ends
`define SAS_BIT_MSB        4'h7

`endif

//--- testbench/sas_cmp_model.sv
// Sample-and-hold and comparator model facing the sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_cmp_model (
  input  wire logic        ref_clk_in,
  input  wire logic [39:0] levels_in,
  input  wire logic [4:0]  mux_sel_in,
  input  wire logic        sample_hold_in,
  input  wire logic        vref_supply_in,
  input  wire logic [7:0]  dac_trial_in,
  output logic             cmp_high_out
);
  logic [7:0] held_q = 8'h00;
  logic       junk_q = 1'b0;
  // Track the selected source; an open input floats
  always @(posedge ref_clk_in) begin
    junk_q <= ~junk_q;
    for (int i = 0; i < 5; i++)
      if (sample_hold_in && mux_sel_in[i]) held_q <= levels_in[8*i +: 8];
  end
  // Supply is the only upper reference; without it the answer is noise
  assign cmp_high_out = (vref_supply_in && mux_sel_in != 5'h00) ?
                        (held_q >= dac_trial_in) : junk_q;
endmodule // sas_cmp_model
`default_nettype wire

//--- testbench/sas_sequencer_monitor.sv
// Port checker for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_monitor (
  input wire logic       ref_clk_in,
  input wire logic       resetn_in,
  input wire logic       ctrl_wr_in,
  input wire logic [2:0] conv_clock_select_in,
  input wire logic       go_in,
  input wire logic       converter_enable_in,
  input wire logic       flag_clr_in,
  input wire logic       conv_complete_irq_enable_in,
  input wire logic       sleep_in,
  input wire logic [2:0] conv_clock_select_out,
  input wire logic [2:0] channel_select_out,
  input wire logic       go_out,
  input wire logic       converter_enable_out,
  input wire logic       conv_complete_flag_out,
  input wire logic [4:0] mux_sel_out,
  input wire logic       vref_supply_out,
  input wire logic       sample_hold_out,
  input wire logic       analog_power_out,
  input wire logic       irq_out,
  input wire logic       wake_out
);
  // ------
  // Properties
  // ------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!resetn_in);
  // Go on a divided clock while enabled; RC start is delayed
  sequence start_s;
    ctrl_wr_in && go_in && converter_enable_in && converter_enable_out && !go_out
      && conv_clock_select_out[1:0] != 2'h3;
  endsequence
  // Go dropped with no write and no sleep
  sequence finish_s;
    $fell(go_out) && !$past(ctrl_wr_in) && !$past(sleep_in);
  endsequence
  start_go_a: assert property (start_s |=> go_out && !sample_hold_out)
    else $error("go write did not start a conversion");
  finish_flag_a: assert property (finish_s |-> conv_complete_flag_out)
    else $error("finish without completion flag");
  flag_hold_a: assert property (conv_complete_flag_out && !flag_clr_in |=> conv_complete_flag_out)
    else $error("flag lost without a clear");
  flag_clear_a: assert property (flag_clr_in && !go_out |=> !conv_complete_flag_out)
    else $error("flag survived a clear");
  irq_wake_a: assert property (irq_out == (conv_complete_flag_out && conv_complete_irq_enable_in)
    && wake_out == (irq_out && sleep_in))
    else $error("interrupt or wake mismatch");
  supply_ref_a: assert property (vref_supply_out)
    else $error("reference not on supply");
  mux_one_a: assert property ($onehot0(mux_sel_out) && ((mux_sel_out == 5'h00)
    == (channel_select_out inside {3'h3, 3'h4, 3'h5})))
    else $error("channel routing wrong");
  enable_run_a: assert property (!converter_enable_out |-> !go_out && !analog_power_out)
    else $error("converter runs while off");
  sleep_abort_a: assert property (sleep_in && go_out && conv_clock_select_out[1:0] != 2'h3
    |-> ##[1:3] (!go_out && !analog_power_out && converter_enable_out))
    else $error("sleep did not abort");
endmodule // sas_sequencer_monitor
bind sas_sequencer sas_sequencer_monitor mon (.*);
`default_nettype wire

//--- testbench/sas_sequencer_tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_sequencer_tb;
  localparam int IC = 4;
  localparam int RCP = 6;
  logic        clk = 0, rst_n = 0, wr = 0, go = 0, en = 0, fclr = 0, ie = 0, slp = 0, rct = 0;
  logic        cmp, go_o, en_o, flag, vsup, sh, pwr, irq, wake;
  logic [2:0]  csel = 0, channel_select = 0, csel_o, chs_o, h;
  logic [7:0]  res, dac, r0;
  logic [4:0]  mux;
  logic [39:0] lv = 0;
  int          fails = 0, compares = 0, t, k, n, rc = 0;
  logic [2:0]  cs [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  logic [2:0]  cl [5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
  sas_sequencer #(.INSTR_CYCLES(IC)) dut (.ref_clk_in(clk), .resetn_in(rst_n), .ctrl_wr_in(wr),
    .conv_clock_select_in(csel), .channel_select_in(channel_select), .go_in(go), .converter_enable_in(en),
    .flag_clr_in(fclr), .conv_complete_irq_enable_in(ie), .sleep_in(slp), .rc_tick_in(rct),
    .cmp_high_in(cmp), .conv_clock_select_out(csel_o), .channel_select_out(chs_o), .go_out(go_o),
    .converter_enable_out(en_o), .conv_complete_flag_out(flag), .conv_result_reg_out(res),
    .mux_sel_out(mux), .vref_supply_out(vsup), .sample_hold_out(sh), .dac_trial_out(dac),
    .analog_power_out(pwr), .irq_out(irq), .wake_out(wake));
  sas_cmp_model model (.ref_clk_in(clk), .levels_in(lv), .mux_sel_in(mux),
    .sample_hold_in(sh), .vref_supply_in(vsup), .dac_trial_in(dac), .cmp_high_out(cmp));
  initial forever #12.5 clk = ~clk;
  // Free-running RC oscillator, one half-period pulse every RCP cycles
  always @(posedge clk) begin
    rc <= (rc == RCP - 1) ? 0 : rc + 1;
    rct <= #2 (rc == 0);
  end
  task automatic end_sim;
    if (fails == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi);
    compares++;
    if (g < lo || g > hi) begin
      fails++;
      $display("[ERR] %0t took %0d not %0d..%0d", $time, g, lo, hi);
    end
  endtask
  task automatic wctl(input logic [2:0] c, input logic [2:0] ch, input logic g, input logic e);
    @(posedge clk);
    #2 {wr, csel, channel_select, go, en} = {1'b1, c, ch, g, e};
    @(posedge clk);
    #2 wr = 0;
  endtask
  // Enable first and let the channel settle before go
  task automatic start(input logic [2:0] c);
    wctl(c, h, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    wctl(c, h, 1'b1, 1'b1);
  endtask
  // Bounded wait for go to drop; t counts the cycles
  task automatic wait_done;
    for (t = 0; go_o === 1'b1 && t < 2000; t++) begin
      @(posedge clk);
      #1;
    end
    #2 if (t >= 2000) begin
      fails++;
      end_sim;
    end
  endtask
  task automatic clr_flag;
    #2 fclr = 1;
    @(posedge clk);
    #2 fclr = 0;
  endtask
  function automatic logic [7:0] lvl(input logic [2:0] c);
    return lv[8 * (c < 3 ? c : c - 3) +: 8];
  endfunction
  // Partial result: m bits done, the rest copy the last
  function automatic logic [7:0] part(input logic [7:0] x, input int m);
    part = (m == 0) ? 8'h00 : x;
    if (m > 0) for (int j = 0; j < 8 - m; j++) part[j] = x[8 - m];
  endfunction
  initial begin
    k = $urandom(53);
    repeat (10) @(posedge clk);
    #2 rst_n = 1;
    chk({2'h0, go_o, en_o, flag, pwr, irq, sh}, 8'h01);
    // Every clock code; rail values first, then random ones
    for (int i = 0; i < 8; i++) begin
      lv = (i < 2) ? {5{{8{i[0]}}}} : {$urandom, 8'($urandom)};
      h = cl[$urandom % 5];
      start(cs[i]);
      wait_done;
      k = (cs[i][1:0] == 2'h3) ? IC + 19 * RCP : 19 << (2 * cs[i][1:0] + cs[i][2]);
      n = (cs[i][1:0] == 2'h3) ? RCP + 2 : 3;
      chk_rng(t, k - n, k + n);
      chk(res, lvl(h));
      chk({7'h0, flag}, 8'h01);
      clr_flag;
      chk({7'h0, flag}, 8'h00);
    end
    for (int i = 3; i < 6; i++) begin
      wctl(3'h0, i[2:0], 1'b0, 1'b1);
      chk({3'h0, mux}, 8'h00);
    end
    // Abort a slow conversion part way
    h = cl[$urandom % 5];
    start(3'h6);
    k = 100 + $urandom % 400;
    repeat (k) @(posedge clk);
    wctl(3'h6, h, 1'b0, 1'b1);
    n = 0;
    for (int m = (k - 94) / 64 - 1; m <= (k - 94) / 64 + 1; m++)
      if (m >= 0 && m < 9 && res === part(lvl(h), m)) n = 1;
    chk({7'h0, n[0]}, 8'h01);
    chk({6'h0, go_o, flag}, 8'h00);
    // Turning off kills a run; go with enable together is refused
    r0 = res;
    start(3'h6);
    repeat (100) @(posedge clk);
    wctl(3'h6, h, 1'b1, 1'b0);
    chk({5'h0, go_o, flag, en_o}, 8'h00);
    chk(res, r0);
    wctl(3'h6, h, 1'b1, 1'b1);
    chk({6'h0, go_o, en_o}, 8'h01);
    // Interrupt awake, then sleep on RC with and without it
    ie = 1;
    start(3'h0);
    wait_done;
    chk({6'h0, irq, wake}, 8'h02);
    clr_flag;
    start(3'h7);
    slp = 1;
    wait_done;
    chk({5'h0, wake, res === lvl(h), flag}, 8'h07);
    {slp, ie} = 0;
    clr_flag;
    start(3'h3);
    slp = 1;
    wait_done;
    @(posedge clk);
    #2 chk({5'h0, pwr, en_o, flag}, 8'h03);
    slp = 0;
    clr_flag;
    // Sleep on a divided clock aborts
    start(3'h1);
    repeat (20) @(posedge clk);
    #2 slp = 1;
    wait_done;
    chk_rng(t, 0, 4);
    chk({5'h0, pwr, en_o, flag}, 8'h02);
    slp = 0;
    // Reset in mid-run
    start(3'h6);
    repeat (50) @(posedge clk);
    #2 rst_n = 0;
    repeat (3) @(posedge clk);
    #2 rst_n = 1;
    chk({go_o, en_o, flag, csel_o, 2'h0}, 8'h00);
    chk(res, 8'h00);
    end_sim;
  end
endmodule // sas_sequencer_tb
`default_nettype wire
